/* design/fcs_sequencer.sv */
// push-button field calibration sequencer with register port and interrupt
`timescale 1ns/1ps
`include "fcs_params.svh"

module fcs_sequencer
#(
    parameter fcs_pkg::fcs_cnt_t DEB_CYC = `FCS_DEB_CYC,
    parameter fcs_pkg::fcs_cnt_t HOLD_CYC = `FCS_HOLD_CYC,
    parameter fcs_pkg::fcs_cnt_t FLASH_CYC = `FCS_FLASH_CYC,
    parameter fcs_pkg::fcs_cnt_t STAT_CYC = `FCS_STAT_CYC,
    parameter fcs_pkg::fcs_cnt_t REPEAT_CYC = `FCS_REPEAT_CYC,
    parameter fcs_pkg::fcs_tmo_t TIMEOUT_CYC = `FCS_TIMEOUT_CYC
)
(
    input wire logic clk, // 40 MHz system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic clk_en, // freezes all state while low
    input wire logic [3:0] btn, // raw buttons: set, mode, up, down
    input wire fcs_pkg::fcs_val_t input_level, // present input measurement
    input wire fcs_pkg::fcs_val_t run_level, // output level in run
    input wire logic alarm_trip, // limit comparator result
    input wire fcs_pkg::fcs_bus_t bus, // register port request
    output logic [31:0] rd_data, // read data, cycle after read
    output fcs_pkg::fcs_val_t out_level, // output level to converter
    output fcs_pkg::fcs_leds_t leds, // front-panel indicators
    output logic alarm_active, // alarm state for relay
    output logic irq // level interrupt
);
    import fcs_pkg::*;

    fcs_regs_t r;
    fcs_regs_t next_r;

    // refuse parameter values the counters cannot serve
    if (DEB_CYC == 0 || HOLD_CYC == 0 || FLASH_CYC == 0 || STAT_CYC == 0 ||
        REPEAT_CYC == 0 || TIMEOUT_CYC == 0)
    begin : g_bad_param
        $error("fcs_sequencer: timing counts must be at least one");
    end

    // clamped trim of the output level
    function automatic fcs_val_t trim(fcs_val_t v, logic up, fcs_val_t d);
        logic [16:0] t;
        t = '0;
        if (up)
        begin
            t = {1'b0, v} + {1'b0, d};
            trim = t[16] ? 16'hFFFF : t[15:0];
        end
        else
        begin
            trim = (v < d) ? 16'h0000 : 16'(v - d);
        end
    endfunction

    // next-state logic
    always_comb
    begin
        fcs_ev_t ev;
        fcs_ev_t clr;
        logic sw_clr;
        logic in_rng;
        logic commit;
        logic ud;
        ev = '0;
        clr = '0;
        sw_clr = 1'b0;
        in_rng = (input_level >= r.range_lo) && (input_level <= r.range_hi);
        commit = 1'b0;
        ud = r.press[`FCS_B_UP] | r.press[`FCS_B_DN];
        next_r = r;
        next_r.press = '0;

        // three-stage sync, then debounce per button
        next_r.s1 = btn;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        for (int i = 0; i < 4; i++)
        begin
            if (r.s2[i] == r.s3[i] && r.s3[i] != r.deb[i])
            begin
                if (r.deb_cnt[i] >= DEB_CYC - 1'b1)
                begin
                    next_r.deb[i] = r.s3[i];
                    next_r.deb_cnt[i] = '0;
                    next_r.press[i] = r.s3[i];
                end
                else
                begin
                    next_r.deb_cnt[i] = r.deb_cnt[i] + 1'b1;
                end
            end
            else
            begin
                next_r.deb_cnt[i] = '0;
            end
        end

        // flash phase and status pulse timers
        if (r.flash_cnt >= FLASH_CYC - 1'b1)
        begin
            next_r.flash_cnt = '0;
            next_r.flash = ~r.flash;
        end
        else
        begin
            next_r.flash_cnt = r.flash_cnt + 1'b1;
        end
        if (r.stat_cnt != '0)
        begin
            next_r.stat_cnt = r.stat_cnt - 1'b1;
        end

        // register writes
        if (bus.wr)
        begin
            case (bus.addr)
                `FCS_A_CTRL:
                begin
                    next_r.fitted = bus.wdata[`FCS_C_FITTED];
                    next_r.latch_mode = bus.wdata[`FCS_C_LATCH];
                    sw_clr = bus.wdata[`FCS_C_ACLR];
                end
                `FCS_A_ISR: clr = bus.wdata[4:0];
                `FCS_A_IMR: next_r.imr = bus.wdata[4:0];
                `FCS_A_RANGE_LO: next_r.range_lo = bus.wdata[15:0];
                `FCS_A_RANGE_HI: next_r.range_hi = bus.wdata[15:0];
                `FCS_A_OUT_ZERO: next_r.out_zero = bus.wdata[15:0];
                `FCS_A_OUT_FS: next_r.out_fs = bus.wdata[15:0];
                default: next_r.imr = r.imr;
            endcase
        end

        // alarm state, latched or following the comparator
        if (r.latch_mode)
        begin
            if (sw_clr || (r.step == ST_RUN && ud))
            begin
                next_r.alarm = 1'b0;
            end
            if (alarm_trip)
            begin
                next_r.alarm = 1'b1;
            end
        end
        else
        begin
            next_r.alarm = alarm_trip;
        end
        ev[`FCS_E_ALARM] = next_r.alarm & ~r.alarm;

        // step sequencing
        if (r.step == ST_RUN)
        begin
            next_r.idle_cnt = '0;
            next_r.hold_cnt = r.deb[`FCS_B_MODE] ? r.hold_cnt + 1'b1 : '0;
            if (r.deb[`FCS_B_MODE] && r.hold_cnt >= HOLD_CYC - 1'b1)
            begin
                next_r.step = ST_ZERO;
                next_r.hold_cnt = '0;
                next_r.adj_done = 1'b0;
                next_r.p_zero = r.a_zero;
                next_r.p_fs = r.a_fs;
                next_r.p_sp = r.a_sp;
                next_r.p_do = r.a_do;
            end
        end
        else
        begin
            next_r.idle_cnt = (|r.press) ? '0 : 33'(r.idle_cnt + 1'b1);

            // capture on set, refused when out of range
            if (r.press[`FCS_B_SET])
            begin
                next_r.stat_cnt = STAT_CYC;
                if (in_rng)
                begin
                    ev[`FCS_E_CAPTURE] = 1'b1;
                    case (r.step)
                        ST_ZERO: next_r.p_zero = input_level;
                        ST_FS: next_r.p_fs = input_level;
                        ST_SP: next_r.p_sp = input_level;
                        ST_DO: next_r.p_do = input_level;
                        default: next_r.p_zero = r.p_zero;
                    endcase
                end
                else
                begin
                    ev[`FCS_E_REJECT] = 1'b1;
                end
            end

            // output adjust in zero and full-scale steps
            if (r.step == ST_ZERO || r.step == ST_FS)
            begin
                if (ud && !r.adj_done)
                begin
                    next_r.adj_done = 1'b1;
                    next_r.out_level = (r.step == ST_ZERO) ? r.out_zero
                                                           : r.out_fs;
                    next_r.rep_cnt = '0;
                end
                else if (ud)
                begin
                    next_r.out_level = trim(r.out_level, r.press[`FCS_B_UP],
                                            `FCS_TRIM_FINE);
                    next_r.rep_cnt = '0;
                end
                else if (r.adj_done &&
                         (r.deb[`FCS_B_UP] ^ r.deb[`FCS_B_DN]))
                begin
                    if (r.rep_cnt >= REPEAT_CYC - 1'b1)
                    begin
                        next_r.rep_cnt = '0;
                        next_r.out_level = trim(r.out_level,
                                                r.deb[`FCS_B_UP],
                                                `FCS_TRIM_COARSE);
                    end
                    else
                    begin
                        next_r.rep_cnt = r.rep_cnt + 1'b1;
                    end
                end
                else
                begin
                    next_r.rep_cnt = '0;
                end
            end

            // mode advances; values move only through set
            if (r.press[`FCS_B_MODE])
            begin
                next_r.adj_done = 1'b0;
                next_r.rep_cnt = '0;
                case (r.step)
                    ST_ZERO: next_r.step = ST_FS;
                    ST_FS:
                    begin
                        if (r.fitted)
                        begin
                            next_r.step = ST_SP;
                        end
                        else
                        begin
                            commit = 1'b1;
                        end
                    end
                    ST_SP: next_r.step = ST_DO;
                    default: commit = 1'b1;
                endcase
            end
            else if (r.idle_cnt >= TIMEOUT_CYC)
            begin
                next_r.step = ST_RUN;
                ev[`FCS_E_TIMEOUT] = 1'b1;
            end
        end

        // return to run with the new scaling
        if (commit)
        begin
            next_r.step = ST_RUN;
            next_r.a_zero = next_r.p_zero;
            next_r.a_fs = next_r.p_fs;
            next_r.a_sp = next_r.p_sp;
            next_r.a_do = next_r.p_do;
            ev[`FCS_E_COMMIT] = 1'b1;
        end

        // derived scaling and deadband
        next_r.span = 16'(next_r.a_fs - next_r.a_zero);
        next_r.deadband = 16'(next_r.a_sp - next_r.a_do);

        // output follows the run path outside configuration
        if (next_r.step == ST_RUN)
        begin
            next_r.out_level = run_level;
        end

        // indicators
        next_r.leds.run = (next_r.step == ST_RUN);
        next_r.leds.scale = (next_r.step == ST_ZERO) ||
                            (next_r.step == ST_FS && next_r.flash);
        case (next_r.step)
            ST_SP: next_r.leds.relay = 1'b1;
            ST_DO: next_r.leds.relay = next_r.flash;
            ST_RUN: next_r.leds.relay = r.fitted & next_r.alarm;
            default: next_r.leds.relay = 1'b0;
        endcase
        next_r.leds.status = (next_r.stat_cnt != '0);

        // sticky events, set wins over clear
        next_r.isr = (r.isr & ~clr) | ev;
        next_r.irq = |(next_r.isr & next_r.imr);

        // register reads, data in the following cycle
        next_r.rd_data = '0;
        if (bus.rd)
        begin
            case (bus.addr)
                `FCS_A_CTRL: next_r.rd_data = {30'h0, r.latch_mode, r.fitted};
                `FCS_A_STATUS: next_r.rd_data = {27'h0, r.alarm,
                                                 1'b0, r.step};
                `FCS_A_ISR: next_r.rd_data = {27'h0, r.isr};
                `FCS_A_IMR: next_r.rd_data = {27'h0, r.imr};
                `FCS_A_RANGE_LO: next_r.rd_data = {16'h0, r.range_lo};
                `FCS_A_RANGE_HI: next_r.rd_data = {16'h0, r.range_hi};
                `FCS_A_OUT_ZERO: next_r.rd_data = {16'h0, r.out_zero};
                `FCS_A_OUT_FS: next_r.rd_data = {16'h0, r.out_fs};
                `FCS_A_ZERO: next_r.rd_data = {16'h0, r.a_zero};
                `FCS_A_FS: next_r.rd_data = {16'h0, r.a_fs};
                `FCS_A_SPAN: next_r.rd_data = {16'h0, r.span};
                `FCS_A_SP: next_r.rd_data = {16'h0, r.a_sp};
                `FCS_A_DO: next_r.rd_data = {16'h0, r.a_do};
                `FCS_A_DBAND: next_r.rd_data = {16'h0, r.deadband};
                default: next_r.rd_data = '0;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r <= '0;
            r.range_hi <= `FCS_RANGE_HI_RST;
            r.out_zero <= `FCS_OUT_ZERO_RST;
            r.out_fs <= `FCS_OUT_FS_RST;
            r.leds.run <= 1'b1;
        end
        else if (clk_en)
        begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign rd_data = r.rd_data;
    assign out_level = r.out_level;
    assign leds = r.leds;
    assign alarm_active = r.alarm;
    assign irq = r.irq;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_enter_config: assert property (
        clk_en && r.step == ST_RUN && r.deb[`FCS_B_MODE] &&
        r.hold_cnt >= HOLD_CYC - 1'b1
        |=> r.step == ST_ZERO && !r.leds.run && r.leds.scale)
        else $error("hold of mode did not enter zero step");

    a_first_adjust: assert property (
        clk_en && r.step == ST_ZERO && r.press[`FCS_B_UP] && !r.adj_done
        |=> r.out_level == $past(r.out_zero))
        else $error("first press did not set zero output");

    a_fine_trim: assert property (
        clk_en && (r.step == ST_ZERO || r.step == ST_FS) && r.adj_done &&
        r.press[`FCS_B_UP] &&
        !r.press[`FCS_B_DN] && !r.press[`FCS_B_MODE] &&
        r.out_level != 16'hFFFF
        |=> r.out_level == $past(r.out_level) + 16'h0001)
        else $error("fine trim step wrong");

    a_coarse_repeat: assert property (
        clk_en && (r.step == ST_ZERO || r.step == ST_FS) && r.adj_done &&
        (r.press == 4'h0) && r.deb[`FCS_B_DN] && !r.deb[`FCS_B_UP] &&
        r.rep_cnt >= REPEAT_CYC - 1'b1 && r.out_level >= 16'h0010
        |=> r.out_level == $past(r.out_level) - 16'h0010)
        else $error("held button did not coarse trim");

    a_status_pulse: assert property (
        clk_en && r.step != ST_RUN && r.press[`FCS_B_SET]
        |=> r.leds.status)
        else $error("set press without status pulse");

    a_zero_to_fs: assert property (
        clk_en && r.step == ST_ZERO && r.press[`FCS_B_MODE]
        |=> r.step == ST_FS)
        else $error("mode in zero step did not advance");

    a_span_value: assert property (
        r.span == 16'(r.a_fs - r.a_zero))
        else $error("span not full-scale minus zero");

    a_fs_next: assert property (
        clk_en && r.step == ST_FS && r.press[`FCS_B_MODE]
        |=> (r.step == ST_SP && r.leds.relay) ^ !$past(r.fitted))
        else $error("wrong step after full-scale");

    a_skip_alarm: assert property (
        clk_en && r.step == ST_FS && r.press[`FCS_B_MODE] && !r.fitted
        |=> r.step == ST_RUN && r.leds.run && !r.leds.scale)
        else $error("no-alarm unit did not return to run");

    a_dband_value: assert property (
        r.deadband == 16'(r.a_sp - r.a_do))
        else $error("deadband not setpoint minus dropout");

    a_no_set_keep: assert property (
        clk_en && r.step != ST_RUN && !r.press[`FCS_B_SET]
        |=> r.p_zero == $past(r.p_zero) && r.p_sp == $past(r.p_sp))
        else $error("pending value changed without set");

    a_timeout_drop: assert property (
        clk_en && r.step != ST_RUN && r.press == 4'h0 &&
        r.idle_cnt >= TIMEOUT_CYC
        |=> r.step == ST_RUN && $stable(r.a_zero) && $stable(r.a_fs))
        else $error("timeout did not discard changes");

    a_reject_range: assert property (
        clk_en && r.press[`FCS_B_SET] && input_level > r.range_hi
        |=> $stable(r.p_zero) && $stable(r.p_fs) && $stable(r.p_do))
        else $error("out-of-range value stored");

    a_latch_hold: assert property (
        clk_en && r.latch_mode && r.alarm && !bus.wr &&
        !(r.press[`FCS_B_UP] | r.press[`FCS_B_DN])
        |=> r.alarm)
        else $error("latched alarm dropped");

    c_full_alarm_pass: cover property (
        r.step == ST_DO && clk_en && r.press[`FCS_B_MODE] ##1 r.leds.run);
    c_timeout_hit: cover property (r.isr[`FCS_E_TIMEOUT]);
    c_reject_hit: cover property (r.isr[`FCS_E_REJECT]);
    c_coarse_hit: cover property (
        r.adj_done && r.rep_cnt >= REPEAT_CYC - 1'b1);
endmodule

/* design/fcs_params.svh */
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH

// clock rate and times in their own units
`define FCS_CLK_HZ 40000000
`define FCS_CYC_PER_MS (`FCS_CLK_HZ / 1000)
`define FCS_DEB_MS 10
`define FCS_HOLD_MS 2000
`define FCS_FLASH_MS 250
`define FCS_STAT_MS 100
`define FCS_REPEAT_MS 200
`define FCS_TIMEOUT_S 120

// derived cycle counts
`define FCS_DEB_CYC (32'(`FCS_DEB_MS) * 32'(`FCS_CYC_PER_MS))
`define FCS_HOLD_CYC (32'(`FCS_HOLD_MS) * 32'(`FCS_CYC_PER_MS))
`define FCS_FLASH_CYC (32'(`FCS_FLASH_MS) * 32'(`FCS_CYC_PER_MS))
`define FCS_STAT_CYC (32'(`FCS_STAT_MS) * 32'(`FCS_CYC_PER_MS))
`define FCS_REPEAT_CYC (32'(`FCS_REPEAT_MS) * 32'(`FCS_CYC_PER_MS))
`define FCS_TIMEOUT_CYC (33'(`FCS_TIMEOUT_S) * 33'(`FCS_CLK_HZ))

// trim steps
`define FCS_TRIM_FINE 16'h0001
`define FCS_TRIM_COARSE 16'h0010

// button index
`define FCS_B_SET 0
`define FCS_B_MODE 1
`define FCS_B_UP 2
`define FCS_B_DN 3

// register byte offsets
`define FCS_A_CTRL 8'h00
`define FCS_A_STATUS 8'h04
`define FCS_A_ISR 8'h08
`define FCS_A_IMR 8'h0C
`define FCS_A_RANGE_LO 8'h10
`define FCS_A_RANGE_HI 8'h14
`define FCS_A_OUT_ZERO 8'h18
`define FCS_A_OUT_FS 8'h1C
`define FCS_A_ZERO 8'h20
`define FCS_A_FS 8'h24
`define FCS_A_SPAN 8'h28
`define FCS_A_SP 8'h2C
`define FCS_A_DO 8'h30
`define FCS_A_DBAND 8'h34

// control bits
`define FCS_C_FITTED 0
`define FCS_C_LATCH 1
`define FCS_C_ACLR 2

// event bits in status and mask
`define FCS_E_CAPTURE 0
`define FCS_E_REJECT 1
`define FCS_E_TIMEOUT 2
`define FCS_E_COMMIT 3
`define FCS_E_ALARM 4

// reset values
`define FCS_RANGE_HI_RST 16'hFFFF
`define FCS_OUT_ZERO_RST 16'h0CCC
`define FCS_OUT_FS_RST 16'hFFFF

`endif

/* design/fcs_pkg.sv */
// types of the field calibration sequencer
package fcs_pkg;
    typedef logic [15:0] fcs_val_t;
    typedef logic [31:0] fcs_cnt_t;
    typedef logic [32:0] fcs_tmo_t;
    typedef logic [4:0] fcs_ev_t;

    typedef enum logic [2:0] {ST_RUN, ST_ZERO, ST_FS, ST_SP, ST_DO} fcs_step_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } fcs_bus_t;

    // front-panel indicators
    typedef struct packed {
        logic run;
        logic scale;
        logic relay;
        logic status;
    } fcs_leds_t;

    // whole state of the sequencer
    typedef struct packed {
        fcs_step_t step;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] deb;
        logic [3:0] press;
        logic [3:0][31:0] deb_cnt;
        fcs_cnt_t hold_cnt;
        fcs_cnt_t rep_cnt;
        fcs_cnt_t flash_cnt;
        fcs_cnt_t stat_cnt;
        fcs_tmo_t idle_cnt;
        logic flash;
        logic adj_done;
        logic alarm;
        logic fitted;
        logic latch_mode;
        fcs_val_t out_level;
        fcs_val_t p_zero;
        fcs_val_t p_fs;
        fcs_val_t p_sp;
        fcs_val_t p_do;
        fcs_val_t a_zero;
        fcs_val_t a_fs;
        fcs_val_t a_sp;
        fcs_val_t a_do;
        fcs_val_t span;
        fcs_val_t deadband;
        fcs_val_t range_lo;
        fcs_val_t range_hi;
        fcs_val_t out_zero;
        fcs_val_t out_fs;
        fcs_ev_t isr;
        fcs_ev_t imr;
        logic [31:0] rd_data;
        logic irq;
        fcs_leds_t leds;
    } fcs_regs_t;
endpackage

/* test/fcs_operator.sv */
// operator model pressing front-panel buttons, with contact bounce
`timescale 1ns/1ps
module fcs_operator
(
    input wire logic clk, // system clock
    output logic [3:0] btn // raw buttons: set, mode, up, down
);
    initial btn = 4'h0;

    // bounce briefly, then hold the button for n cycles and let go
    task automatic push(input int b, input int n);
        @(posedge clk) btn[b] <= 1'b1;
        repeat (2) @(posedge clk);
        btn[b] <= 1'b0;
        @(posedge clk) btn[b] <= 1'b1;
        repeat (n) @(posedge clk);
        btn[b] <= 1'b0;
        repeat (15) @(posedge clk);
    endtask
endmodule

/* test/tb.sv */
// self-checking bench of the field calibration sequencer
`timescale 1ns/1ps
`include "fcs_params.svh"
module tb;
    import fcs_pkg::*;
    logic clk, sys_rst, alarm_trip, st_prev, clk_en;
    logic [3:0] btn;
    fcs_val_t input_level, out_level, run_level;
    fcs_bus_t bus;
    logic [31:0] rd_data, d;
    fcs_leds_t leds;
    logic alarm_active, irq;
    int errors, check_count, pulses, n, hi;

    // shortened timing so every step fits in a short run
    localparam fcs_cnt_t DEB_T = 32'd4;
    localparam fcs_cnt_t HOLD_T = 32'd20;
    localparam fcs_cnt_t FLASH_T = 32'd8;
    localparam fcs_cnt_t STAT_T = 32'd5;
    localparam fcs_cnt_t REP_T = 32'd10;
    localparam fcs_tmo_t TMO_T = 33'd200;

    fcs_sequencer #(.DEB_CYC(DEB_T), .HOLD_CYC(HOLD_T), .FLASH_CYC(FLASH_T),
        .STAT_CYC(STAT_T), .REPEAT_CYC(REP_T), .TIMEOUT_CYC(TMO_T))
        fcs_sequencer_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .btn(btn), .input_level(input_level), .run_level(run_level),
        .alarm_trip(alarm_trip), .bus(bus), .rd_data(rd_data),
        .out_level(out_level), .leds(leds), .alarm_active(alarm_active),
        .irq(irq));
    fcs_operator fcs_operator_i (.clk(clk), .btn(btn));

    // clock, 25 ns period
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // count rising edges of the status led
    always @(posedge clk)
    begin
        if (leds.status === 1'b1 && st_prev !== 1'b1) pulses++;
        st_prev = leds.status;
    end

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus <= '0;
    endtask

    // read data stand in the cycle after the strobe
    task automatic rd(logic [7:0] a, output logic [31:0] v);
        @(posedge clk) bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0,
            rd: 1'b1};
        @(posedge clk) bus <= '0;
        #1 v = rd_data;
    endtask

    task automatic conclude();
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic s_reset();
        chk("run led", 1, leds.run);
        rd(`FCS_A_RANGE_HI, d);
        chk("range_hi", 32'h0000_FFFF, d);
        rd(8'hFC, d);
        chk("unmapped", 32'h0000_0000, d);
        chk("run output", 32'h0000_0777, out_level);
    endtask

    // clock enable low freezes the output path
    task automatic s_freeze();
        @(posedge clk) clk_en <= 1'b0;
        run_level <= 16'h0888;
        repeat (3) @(posedge clk);
        chk("frozen output", 32'h0000_0777, out_level);
        clk_en <= 1'b1;
        repeat (2) @(posedge clk);
        chk("run follow", 32'h0000_0888, out_level);
    endtask

    task automatic s_enter_trim();
        wr(`FCS_A_IMR, 32'h0000_0001);
        fcs_operator_i.push(`FCS_B_MODE, 40);
        rd(`FCS_A_STATUS, d);
        chk("step zero", 1, d[2:0]);
        chk("leds", 3'b010, {leds.run, leds.scale, leds.relay});
        fcs_operator_i.push(`FCS_B_UP, 10);
        chk("auto zero", 16'h0CCC, out_level);
        fcs_operator_i.push(`FCS_B_UP, 10);
        chk("fine trim", 16'h0CCD, out_level);
        fcs_operator_i.push(`FCS_B_DN, 40);
        chk("coarse trim", 16'h0C9C, out_level);
    endtask

    task automatic s_capture_commit();
        input_level <= 16'h1234;
        n = pulses;
        fcs_operator_i.push(`FCS_B_SET, 10);
        chk("status pulses", n + 1, pulses);
        chk("irq set", 1, irq);
        wr(`FCS_A_ISR, 32'h0000_0001);
        @(posedge clk) #1 chk("irq clear", 0, irq);
        fcs_operator_i.push(`FCS_B_MODE, 10);
        rd(`FCS_A_STATUS, d);
        chk("step fs", 2, d[2:0]);
        hi = 0;
        repeat (20) @(posedge clk) hi += leds.scale;
        chk("scale flash", 1, hi > 0 && hi < 20);
        input_level <= 16'h5234;
        fcs_operator_i.push(`FCS_B_SET, 10);
        fcs_operator_i.push(`FCS_B_MODE, 10);
        chk("run leds", 2'b10, {leds.run, leds.scale});
        rd(`FCS_A_SPAN, d);
        chk("span", 32'h0000_4000, d);
        rd(`FCS_A_ZERO, d);
        chk("zero", 32'h0000_1234, d);
    endtask

    task automatic s_reject_timeout();
        wr(`FCS_A_RANGE_HI, 32'h0000_2000);
        fcs_operator_i.push(`FCS_B_MODE, 40);
        input_level <= 16'h3000;
        fcs_operator_i.push(`FCS_B_SET, 10);
        rd(`FCS_A_ISR, d);
        chk("reject", 1, d[`FCS_E_REJECT]);
        fcs_operator_i.push(`FCS_B_MODE, 10);
        input_level <= 16'h0100;
        fcs_operator_i.push(`FCS_B_SET, 10);
        repeat (210) @(posedge clk);
        rd(`FCS_A_STATUS, d);
        chk("timeout step", 0, d[2:0]);
        chk("timeout run", 1, leds.run);
        rd(`FCS_A_FS, d);
        chk("fs kept", 32'h0000_5234, d);
    endtask

    // alarm unit: setpoint and dropout steps, then latched alarm
    task automatic s_alarm_cfg();
        wr(`FCS_A_CTRL, 32'h0000_0003);
        fcs_operator_i.push(`FCS_B_MODE, 40);
        fcs_operator_i.push(`FCS_B_MODE, 10);
        fcs_operator_i.push(`FCS_B_MODE, 10);
        rd(`FCS_A_STATUS, d);
        chk("step sp", 3, d[2:0]);
        chk("relay steady", 2'b01, {leds.scale, leds.relay});
        input_level <= 16'h1800;
        fcs_operator_i.push(`FCS_B_SET, 10);
        fcs_operator_i.push(`FCS_B_MODE, 10);
        rd(`FCS_A_STATUS, d);
        chk("step do", 4, d[2:0]);
        hi = 0;
        repeat (20) @(posedge clk) hi += leds.relay;
        chk("relay flash", 1, hi > 0 && hi < 20);
        input_level <= 16'h1000;
        fcs_operator_i.push(`FCS_B_SET, 10);
        fcs_operator_i.push(`FCS_B_MODE, 10);
        rd(`FCS_A_SP, d);
        chk("setpoint", 32'h0000_1800, d);
        rd(`FCS_A_DBAND, d);
        chk("deadband", 32'h0000_0800, d);
        rd(`FCS_A_FS, d);
        chk("fs unchanged", 32'h0000_5234, d);
        @(posedge clk) alarm_trip <= 1'b1;
        @(posedge clk) alarm_trip <= 1'b0;
        repeat (2) @(posedge clk);
        chk("alarm latched", 1, alarm_active);
        chk("relay alarm", 1, leds.relay);
        fcs_operator_i.push(`FCS_B_UP, 10);
        chk("button clear", 0, alarm_active);
        @(posedge clk) alarm_trip <= 1'b1;
        @(posedge clk) alarm_trip <= 1'b0;
        wr(`FCS_A_CTRL, 32'h0000_0007);
        @(posedge clk) chk("sw clear", 0, alarm_active);
    endtask

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end

    initial
    begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        run_level = 16'h0777;
        alarm_trip = 1'b0;
        input_level = 16'h0000;
        bus = '0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        s_reset();
        s_freeze();
        s_enter_trim();
        s_capture_commit();
        s_reject_timeout();
        s_alarm_cfg();
        conclude();
    end
endmodule
